// File: apt_cfg.svh
// Constants of the audio serial port
`ifndef APT_CFG_SVH
`define APT_CFG_SVH
`define APT_CLK_KHZ      100000
`define APT_PCM_BCLK_KHZ 2048
`define APT_PCM_FS_KHZ   8
`define APT_I2S_BCLK_KHZ 1536
`define APT_I2S_FS_KHZ   48
// Half period rounds up so the clock never runs fast
`define APT_HALF(k)      ((`APT_CLK_KHZ + 2 * (k) - 1) / (2 * (k)))
`define APT_PCM_HALF     6'(`APT_HALF(`APT_PCM_BCLK_KHZ))
`define APT_I2S_HALF     6'(`APT_HALF(`APT_I2S_BCLK_KHZ))
`define APT_PCM_LAST     8'(`APT_PCM_BCLK_KHZ / `APT_PCM_FS_KHZ - 1)
`define APT_I2S_LAST     5'(`APT_I2S_BCLK_KHZ / `APT_I2S_FS_KHZ - 1)
`define APT_WS_HIGH      5'hF
`define APT_SLOT_LAST    8'hF
`define APT_OFF_CTRL     5'h00
`define APT_OFF_STAT     5'h04
`define APT_OFF_TXA      5'h08
`define APT_OFF_TXB      5'h0C
`define APT_OFF_RXA      5'h10
`define APT_OFF_RXB      5'h14
`define APT_C_EN         0
`define APT_C_I2S        1
`define APT_C_MST        2
`define APT_C_ENC        4:3
`define APT_C_USB        5
`define APT_C_VOL        7:6
`define APT_S_RX         0
`define APT_S_TX         1
`define APT_S_ACT        2
`define APT_S_CLK        3
`endif

// File: apt_pkg.sv
// Types of the audio serial port
package apt_pkg;
  typedef enum logic [1:0] {
    APT_ENC_LIN  = 2'h0,
    APT_ENC_ALAW = 2'h1,
    APT_ENC_ULAW = 2'h2,
    APT_ENC_RSV  = 2'h3
  } apt_enc_e;
  typedef enum logic {
    APT_PCM = 1'h0,
    APT_I2S = 1'h1
  } apt_mode_e;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
  } apt_sync_s;
  typedef struct packed {
    logic [5:0] cnt;
    logic       bclk;
    logic       rise;
    logic       fall;
  } apt_bclk_s;
  typedef struct packed {
    logic        en;
    apt_mode_e   mode;
    logic        mst;
    apt_enc_e    enc;
    logic        usb;
    logic [1:0]  vol;
    logic        st_rx;
    logic        st_tx;
    logic [15:0] tx_a;
    logic [15:0] tx_b;
    logic [15:0] rx_a;
    logic [15:0] rx_b;
    logic        waitreq;
    logic [31:0] rdata;
    logic [7:0]  cnt;
    logic        act;
    logic [31:0] sh_tx;
    logic [31:0] sh_rx;
    logic        dout;
    logic        dout_oe;
    logic        cs;
    logic        cs_oe;
    logic        bclk_oe;
    logic [15:0] usb_data;
    logic        usb_vld;
  } apt_port_s;
endpackage

// File: apt_sync.sv
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ns
module apt_sync (
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic [2:0] d_i,
  output logic [2:0] q_o,
  output logic [2:0] qd_o
);
  apt_pkg::apt_sync_s s, n;

  // First stage feeds only the second
  always_comb begin
    n    = s;
    n.s1 = d_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q_o  = s.s2;
  assign qd_o = s.s3;
endmodule

// File: apt_bclk.sv
// Bit clock divider with edge pulses
`timescale 1ns/1ns
module apt_bclk (
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic       run_i,
  input  logic [5:0] half_i,
  output logic       bclk_o,
  output logic       rise_o,
  output logic       fall_o
);
  apt_pkg::apt_bclk_s s, n;

  // Pulses stand in the cycle the clock level changes
  always_comb begin
    n      = s;
    n.rise = 1'h0;
    n.fall = 1'h0;
    if (!run_i) begin
      n.cnt  = 6'h0;
      n.bclk = 1'h0;
    end else if (s.cnt == half_i - 6'h1) begin
      n.cnt  = 6'h0;
      n.bclk = ~s.bclk;
      n.rise = ~s.bclk;
      n.fall = s.bclk;
    end else begin
      n.cnt = s.cnt + 6'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bclk_o = s.bclk;
  assign rise_o = s.rise;
  assign fall_o = s.fall;
endmodule

// File: apt_port.sv
// PCM / I2S audio serial port with Avalon-MM registers
`timescale 1ns/1ns
`include "apt_cfg.svh"
module apt_port (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic [4:0]  avs_address_i,
  input  logic        avs_read_i,
  input  logic        avs_write_i,
  input  logic [31:0] avs_writedata_i,
  input  logic [3:0]  avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic        avs_waitrequest_o,
  input  logic        bclk_i,
  output logic        bclk_o,
  output logic        bclk_oe_o,
  input  logic        channel_select_pin_i,
  output logic        channel_select_pin_o,
  output logic        channel_select_pin_oe_o,
  input  logic        din_i,
  output logic        dout_o,
  output logic        dout_oe_o,
  output logic [15:0] usb_data_o,
  output logic        usb_valid_o
);
  apt_pkg::apt_port_s s, n;
  logic [2:0] pin_q;
  logic [2:0] pin_qd;
  logic       run;
  logic       g_rise;
  logic       g_fall;
  logic       rise;
  logic       fall;
  logic       fs;
  logic [5:0] half;
  logic [7:0] gap;

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i+:8] = w[8*i+:8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ctrl_word(input apt_pkg::apt_port_s x);
    logic [31:0] r;
    r = 32'h0;
    r[`APT_C_EN]  = x.en;
    r[`APT_C_I2S] = x.mode;
    r[`APT_C_MST] = x.mst;
    r[`APT_C_ENC] = x.enc;
    r[`APT_C_USB] = x.usb;
    r[`APT_C_VOL] = x.vol;
    return r;
  endfunction

  // Companding itself is left to software; bytes ride in the upper half
  function automatic logic [15:0] tx_fmt(input logic [15:0] w, input apt_pkg::apt_enc_e e,
                                         input logic [1:0] v);
    if (e == apt_pkg::APT_ENC_LIN) begin
      return {w[15:2], v};
    end
    return {w[7:0], 8'h00};
  endfunction

  function automatic logic [15:0] rx_fmt(input logic [15:0] w, input apt_pkg::apt_enc_e e);
    if (e == apt_pkg::APT_ENC_LIN) begin
      return w;
    end
    return {8'h00, w[15:8]};
  endfunction

  apt_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bclk_i, channel_select_pin_i, din_i}),
    .q_o   (pin_q),
    .qd_o  (pin_qd)
  );

  assign run  = s.en && (s.mode == apt_pkg::APT_I2S || s.mst);
  assign half = (s.mode == apt_pkg::APT_I2S) ? `APT_I2S_HALF : `APT_PCM_HALF;

  apt_bclk u_bclk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (run),
    .half_i (half),
    .bclk_o (bclk_o),
    .rise_o (g_rise),
    .fall_o (g_fall)
  );

  // Slave edges lag the pin by the synchroniser; data lags equally
  assign rise = run ? g_rise : (pin_q[2] & ~pin_qd[2]);
  assign fall = run ? g_fall : (~pin_q[2] & pin_qd[2]);
  assign fs   = s.mst ? s.cs : pin_q[1];

  always_comb begin
    logic [31:0] w;
    logic [31:0] rsh;
    logic [4:0]  nc;
    w         = 32'h0;
    rsh       = 32'h0;
    nc        = 5'h0;
    n         = s;
    n.waitreq = 1'h1;
    n.usb_vld = 1'h0;
    // One access per request, answered after one wait cycle
    if ((avs_read_i || avs_write_i) && s.waitreq) begin
      n.waitreq = 1'h0;
      n.rdata   = 32'h0;
      case (avs_address_i)
        `APT_OFF_CTRL: begin
          n.rdata = ctrl_word(s);
          if (avs_write_i) begin
            w      = be_merge(ctrl_word(s), avs_writedata_i, avs_byteenable_i);
            n.en   = w[`APT_C_EN];
            n.mode = apt_pkg::apt_mode_e'(w[`APT_C_I2S]);
            n.mst  = w[`APT_C_MST];
            n.enc  = apt_pkg::apt_enc_e'(w[`APT_C_ENC]);
            n.usb  = w[`APT_C_USB];
            n.vol  = w[`APT_C_VOL];
          end
        end
        `APT_OFF_STAT: begin
          n.rdata[`APT_S_RX]  = s.st_rx;
          n.rdata[`APT_S_TX]  = s.st_tx;
          n.rdata[`APT_S_ACT] = s.act;
          n.rdata[`APT_S_CLK] = s.bclk_oe;
          if (avs_write_i && avs_byteenable_i[0]) begin
            n.st_rx = s.st_rx & ~avs_writedata_i[`APT_S_RX];
            n.st_tx = s.st_tx & ~avs_writedata_i[`APT_S_TX];
          end
        end
        `APT_OFF_TXA: begin
          n.rdata = {16'h0, s.tx_a};
          if (avs_write_i) begin
            w      = be_merge({16'h0, s.tx_a}, avs_writedata_i, avs_byteenable_i);
            n.tx_a = w[15:0];
          end
        end
        `APT_OFF_TXB: begin
          n.rdata = {16'h0, s.tx_b};
          if (avs_write_i) begin
            w      = be_merge({16'h0, s.tx_b}, avs_writedata_i, avs_byteenable_i);
            n.tx_b = w[15:0];
          end
        end
        `APT_OFF_RXA: begin
          n.rdata = {16'h0, s.rx_a};
        end
        `APT_OFF_RXB: begin
          n.rdata = {16'h0, s.rx_b};
        end
        default: begin
          n.rdata = 32'h0;
        end
      endcase
    end
    n.bclk_oe = run;
    n.cs_oe   = run;
    // Frame events come after the bus so a set beats a clear
    if (!s.en) begin
      n.act     = 1'h0;
      n.cnt     = 8'h0;
      n.cs      = 1'h0;
      n.dout_oe = 1'h0;
    end else if (s.mode == apt_pkg::APT_PCM) begin
      if (rise) begin
        if (s.mst) begin
          n.cs = (s.cnt == `APT_PCM_LAST);
        end
        n.dout    = s.sh_tx[31];
        n.dout_oe = s.act && !s.usb;
      end
      if (fall) begin
        if (fs) begin
          n.cnt   = 8'h0;
          n.act   = 1'h1;
          n.st_tx = 1'h1;
          n.sh_tx = {16'h0, tx_fmt(s.tx_a, s.enc, s.vol)} << 16;
          if (s.usb) begin
            n.usb_data = tx_fmt(s.tx_a, s.enc, s.vol);
            n.usb_vld  = 1'h1;
          end
        end else begin
          n.cnt = s.cnt + 8'h1;
          if (s.act) begin
            rsh     = {s.sh_rx[30:0], pin_q[0]};
            n.sh_rx = rsh;
            n.sh_tx = s.sh_tx << 1;
            if (s.cnt == `APT_SLOT_LAST) begin
              n.act     = 1'h0;
              n.dout_oe = 1'h0;
              n.rx_a    = rx_fmt(rsh[15:0], s.enc);
              n.st_rx   = 1'h1;
            end
          end
        end
      end
    end else begin
      // Channel select leads the data by one bit
      if (fall) begin
        nc        = s.cnt[4:0] + 5'h1;
        n.cnt     = {3'h0, nc};
        n.dout_oe = 1'h1;
        n.cs      = nc >= `APT_WS_HIGH && nc != `APT_I2S_LAST;
        if (nc == 5'h0) begin
          n.sh_tx = {s.tx_a, s.tx_b};
          n.dout  = s.tx_a[15];
          n.st_tx = 1'h1;
        end else begin
          n.dout = s.sh_tx[~nc];
        end
      end
      if (rise) begin
        rsh     = {s.sh_rx[30:0], pin_q[0]};
        n.sh_rx = rsh;
        if (s.cnt[4:0] == `APT_I2S_LAST) begin
          n.rx_a  = rsh[31:16];
          n.rx_b  = rsh[15:0];
          n.st_rx = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.waitreq <= 1'h1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata_o          = s.rdata;
  assign avs_waitrequest_o       = s.waitreq;
  assign bclk_oe_o               = s.bclk_oe;
  assign channel_select_pin_o    = s.cs;
  assign channel_select_pin_oe_o = s.cs_oe;
  assign dout_o                  = s.dout;
  assign dout_oe_o               = s.dout_oe;
  assign usb_data_o              = s.usb_data;
  assign usb_valid_o             = s.usb_vld;

  // Cycles since the last generated clock edge
  always_ff @(posedge clk_i) begin
    // Preload all ones so the first half period counts like the rest
    if (rst_i || !run) begin
      gap <= 8'hFF;
    end else if (rise || fall) begin
      gap <= 8'h0;
    end else if (gap != 8'hFE) begin
      gap <= gap + 8'h1;
    end
  end

  a_bclk_half_pcm: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && s.mode == apt_pkg::APT_PCM && (rise || fall)) |-> gap == {2'h0, `APT_PCM_HALF - 6'h1})
    else $error("PCM bit clock half period wrong");
  a_bclk_half_i2s: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && s.mode == apt_pkg::APT_I2S && (rise || fall)) |-> gap == {2'h0, `APT_I2S_HALF - 6'h1})
    else $error("I2S bit clock half period wrong");
  a_pcm_launch_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_PCM && $rose(s.dout_oe)) |-> $past(rise))
    else $error("PCM output enabled off a rising edge");
  a_pcm_hiz_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_PCM && !s.usb && $fell(s.dout_oe)) |-> $past(fall))
    else $error("PCM output released off a falling edge");
  a_slot_sixteen: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_PCM && $fell(s.act)) |-> $past(s.cnt) == `APT_SLOT_LAST)
    else $error("PCM slot not sixteen bits");
  a_frame_start: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_PCM && fall && fs && !avs_write_i)
    |=> (s.cnt == 8'h0 && s.act))
    else $error("PCM frame not started by sync");
  a_sync_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_PCM && s.mst && $rose(s.cs))
    |-> ($past(rise) && $past(s.cnt) == `APT_PCM_LAST))
    else $error("PCM sync raised at wrong bit");
  a_ws_channel: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_I2S && $past(fall) && $past(s.mode) == apt_pkg::APT_I2S)
    |-> s.cs == (s.cnt[4:0] inside {[5'hF:5'h1E]}))
    else $error("I2S channel select wrong");
  a_i2s_master: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_I2S && $past(s.en) && $past(s.mode) == apt_pkg::APT_I2S)
    |-> (s.bclk_oe && s.cs_oe))
    else $error("I2S not driving clock and select");
  a_slave_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.mode == apt_pkg::APT_PCM && !s.mst && $past(s.mode) == apt_pkg::APT_PCM && !$past(s.mst))
    |-> (!s.bclk_oe && !s.cs_oe))
    else $error("PCM slave drives clock or sync");
  a_usb_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_PCM && s.usb && rise) |=> !s.dout_oe)
    else $error("PCM output driven while routed to USB");
  a_rx_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.en && s.mode == apt_pkg::APT_PCM && $changed(s.sh_rx)) |-> $past(fall))
    else $error("PCM input sampled off a falling edge");
endmodule

// File: apt_codec.sv
// Behavioural audio codec on the far side of the serial port pins
`timescale 1ns/1ns
module apt_codec (
  input  logic bclk_i,
  input  logic sync_i,
  input  logic dout_i,
  input  logic dout_oe_i,
  output logic bclk_o,
  output logic sync_o,
  output logic din_o
);
  logic        i2s = 1'b0;
  logic        act = 1'b0;
  logic        ws_q = 1'b0;
  logic [15:0] tx_pcm = '0;
  logic [15:0] tx_l = '0;
  logic [15:0] tx_r = '0;
  logic [15:0] sh_rx = '0;
  logic [15:0] rx_word = '0;
  logic [15:0] sh_i2s = '0;
  logic [15:0] i2s_l = '0;
  logic [15:0] i2s_r = '0;
  int          bit_n = 0;
  int          oe_cnt = 0;
  int          n_frames = 0;
  int          n_i2s = 0;
  int          idx = 0;
  time         t_fall = 0;
  time         per = 0;
  time         t_frame = 0;
  time         t_prev = 0;

  initial begin
    bclk_o = 1'b0;
    sync_o = 1'b0;
    din_o = 1'b0;
  end

  // Falling edge: frame start on sync, then 16 samples of the port's output
  always @(negedge bclk_i) begin
    per = $time - t_fall;
    t_fall = $time;
    if (!i2s && sync_i) begin
      act = 1'b1;
      bit_n = 0;
      oe_cnt = 0;
      t_prev = t_frame;
      t_frame = $time;
    end else if (act) begin
      sh_rx = {sh_rx[14:0], dout_i};
      oe_cnt += int'(dout_oe_i);
      bit_n++;
      if (bit_n == 16) begin
        act = 1'b0;
        rx_word = sh_rx;
        n_frames++;
      end
    end
    if (i2s)
      din_o = ws_q ? tx_r[15 - idx] : tx_l[15 - idx];
  end

  // Rising edge: PCM bits launched here; I2S words close when select flips
  always @(posedge bclk_i) begin
    if (i2s) begin
      if (sync_i != ws_q) begin
        if (ws_q)
          i2s_r = {sh_i2s[14:0], dout_i};
        else
          i2s_l = {sh_i2s[14:0], dout_i};
        n_i2s++;
        idx = 0;
      end else if (idx < 15)
        idx++;
      sh_i2s = {sh_i2s[14:0], dout_i};
      ws_q = sync_i;
    end else
      din_o = act ? tx_pcm[15 - bit_n] : !din_o;
  end

  // Slave frame: clock runs only around the slot, held low in between
  task automatic slave_frame();
    for (int k = 0; k < 18; k++) begin
      #62 bclk_o = 1'b1;
      sync_o = (k == 0);
      #63 bclk_o = 1'b0;
    end
  endtask
endmodule

// File: tb_apt_port.sv
// Self-checking bench for the audio serial port
`timescale 1ns/1ns
`include "apt_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_apt_port;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  avs_address_i = '0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        bclk_o, bclk_oe_o, cs_o, cs_oe_o, dout_o, dout_oe_o;
  logic [15:0] usb_data_o;
  logic        usb_valid_o;
  logic        cdc_bclk, cdc_sync, cdc_din;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // Pins resolved from the port's enables alone
  wire bclk_w = bclk_oe_o ? bclk_o : cdc_bclk;
  wire sync_w = cs_oe_o ? cs_o : cdc_sync;
  // Released data pin shows the inverse, so an early release spoils the word
  wire dout_w = dout_oe_o ? dout_o : ~dout_o;

  apt_port apt_port_inst (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .bclk_i(bclk_w), .bclk_o(bclk_o),
    .bclk_oe_o(bclk_oe_o), .channel_select_pin_i(sync_w), .channel_select_pin_o(cs_o),
    .channel_select_pin_oe_o(cs_oe_o), .din_i(cdc_din), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .usb_data_o(usb_data_o), .usb_valid_o(usb_valid_o));
  apt_codec apt_codec_inst (.bclk_i(bclk_w), .sync_i(sync_w), .dout_i(dout_w),
    .dout_oe_i(dout_oe_o), .bclk_o(cdc_bclk), .sync_o(cdc_sync), .din_o(cdc_din));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Five master frames of 128 us dominate the run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      $display("Error at %0t: timeout", $time);
      stop_test();
    end
  end

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= we;
    avs_read_i <= !we;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 4'hF, q);
  endtask

  task automatic wait_frame();
    int n;
    n = apt_codec_inst.n_frames;
    while (apt_codec_inst.n_frames == n) @(posedge clk_i);
  endtask

  initial begin
    logic [31:0] q;
    logic [15:0] tx;
    repeat (20) @(posedge clk_i);
    `CHK({bclk_oe_o, cs_oe_o, dout_oe_o}, 3'b000)
    rst_i <= 1'b0;
    rd(`APT_OFF_CTRL, q);
    `CHK(q, 32'h0)
    bus(1'b1, `APT_OFF_CTRL, 32'hFF, 4'h0, q);
    rd(`APT_OFF_CTRL, q);
    `CHK(q, 32'h0)
    wr(`APT_OFF_RXA, 32'h1234);
    rd(`APT_OFF_RXA, q);
    `CHK(q, 32'h0)
    rd(5'h18, q);
    `CHK(q, 32'h0)
    // Master PCM in each encoding, frames back to back
    for (int e = 0; e < 4; e++) begin
      tx = 16'h3C5A + 16'(e * 16'h1111);
      apt_codec_inst.tx_pcm = tx;
      wr(`APT_OFF_TXA, 32'hA5C3);
      wr(`APT_OFF_CTRL, {24'h0, 2'b10, 1'b0, e[1:0], 1'b1, 1'b0, 1'b1});
      wait_frame();
      `CHK(apt_codec_inst.rx_word, (e != 0) ? 16'hC300 : 16'hA5C2)
      `CHK(apt_codec_inst.oe_cnt, 16)
      rd(`APT_OFF_STAT, q);
      `CHK({q[3], q[1:0]}, 3'b111)
      `CHK(dout_oe_o, 1'b0)
      rd(`APT_OFF_RXA, q);
      `CHK(q[15:0], (e != 0) ? {8'h00, tx[15:8]} : tx)
      wr(`APT_OFF_STAT, 32'h3);
      rd(`APT_OFF_STAT, q);
      `CHK(q[1:0], 2'b00)
    end
    `CHK(apt_codec_inst.t_frame - apt_codec_inst.t_prev, 64'(256 * 50 * 10))
    `CHK(apt_codec_inst.per >= 488, 1'b1)
    // Outgoing word diverted to USB, pin left undriven
    wr(`APT_OFF_TXA, 32'h1234);
    wr(`APT_OFF_CTRL, 32'hE5);
    while (usb_valid_o !== 1'b1) @(posedge clk_i);
    `CHK(usb_data_o, 16'h1237)
    wait_frame();
    `CHK(apt_codec_inst.oe_cnt, 0)
    // Slave PCM: far side clocks one fast frame
    wr(`APT_OFF_CTRL, 32'h1);
    wr(`APT_OFF_TXA, 32'hC3F0);
    `CHK({bclk_oe_o, cs_oe_o}, 2'b00)
    apt_codec_inst.tx_pcm = 16'h5AA5;
    apt_codec_inst.slave_frame();
    `CHK(apt_codec_inst.rx_word, 16'hC3F0)
    rd(`APT_OFF_RXA, q);
    `CHK(q[15:0], 16'h5AA5)
    // I2S stereo both ways
    apt_codec_inst.tx_l = 16'h2468;
    apt_codec_inst.tx_r = 16'hACE1;
    apt_codec_inst.i2s = 1'b1;
    wr(`APT_OFF_TXA, 32'hBEEF);
    wr(`APT_OFF_TXB, 32'h1357);
    wr(`APT_OFF_CTRL, 32'h3);
    while (apt_codec_inst.n_i2s < 8) @(posedge clk_i);
    `CHK({bclk_oe_o, cs_oe_o}, 2'b11)
    `CHK({apt_codec_inst.i2s_l, apt_codec_inst.i2s_r}, 32'hBEEF1357)
    `CHK(apt_codec_inst.per >= 651, 1'b1)
    rd(`APT_OFF_RXA, q);
    `CHK(q[15:0], 16'h2468)
    rd(`APT_OFF_RXB, q);
    `CHK(q[15:0], 16'hACE1)
    stop_test();
  end
endmodule
